// [dv/asp_link_peer.sv]
// Partner: far-side I2S converter making bit clock, frame and data
`timescale 1ns/10ps
module asp_link_peer (
  input wire logic run, // Send frames
  input wire logic short_frm, // Cut half-frames short
  output logic sck, // Bit clock, one for all ports
  output logic ws, // Frame clock
  output logic sd // Serial data
);
  int n;
  initial
  begin
    sck = 1'b0;
    ws = 1'b0;
    sd = 1'b0;
    forever
    begin
      // Clock stands still while run is low, data line wanders
      if (!run)
        #160 sd = ~sd;
      else
      begin
        for (n = 0; n < (short_frm ? 20 : 24); n++)
        begin
          #160 sck = 1'b1;
          #160 sck = 1'b0;
          sd = 1'($urandom);
        end
        ws = ~ws;
      end
    end
  end
endmodule // asp_link_peer

// [dv/asp_pin_mux_properties.sv]
// Checker: mode control and pin routing of the audio pin mux
`timescale 1ns/10ps
module asp_pin_mux_props (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic mode_wr, // Write strobe
  input wire logic [1:0] mode_wdata, // Write code
  input asp_pkg::asp_mode_e mode_o, // Mode in force
  input wire logic mode_busy, // Switching
  input wire logic mode_err, // Refused
  input asp_pkg::asp_drv_s spi_drv, // SPI drive
  input asp_pkg::asp_drv_s ac_drv, // Codec drive
  input asp_pkg::asp_drv_s i2s_drv, // I2S drive
  input wire logic ac_rst_n, // Codec reset
  input wire logic i2s_mclk, // Master clock
  input wire logic sync_port_serial_out_pin_o, // Pin
  input wire logic audio_codec_serial_out_pin_o, // Pin
  input wire logic audio_codec_reset_pin_o // Pin
);
  import asp_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic quiet;
  logic [10:0] busy_cnt;
  assign quiet = !mode_wr && !mode_busy;
  // Consecutive busy cycles, bounded by the wait plus the gap
  always_ff @(posedge clk)
    busy_cnt <= (rst || !mode_busy) ? 11'h000 : busy_cnt + 11'h001;
  // ==========================================================
  // Mode control
  a_reset_normal: assert property ($fell(rst) |->
    mode_o == ASP_MODE_NORMAL) else $error("mode not normal after reset");
  a_bad_code: assert property (!mode_busy && mode_wr &&
    mode_wdata == 2'h3 |=> mode_err && $stable(mode_o))
    else $error("illegal code not refused");
  a_err_cause: assert property (mode_err |-> $past(mode_wr) &&
    ($past(mode_busy) || $past(mode_wdata) == 2'h3))
    else $error("error pulse without cause");
  a_gap_switch: assert property (mode_wr && !mode_busy &&
    mode_o == ASP_MODE_NORMAL && mode_wdata inside {2'h1, 2'h2} |=>
    mode_busy ##2 !mode_busy && mode_o == $past(mode_wdata, 3))
    else $error("switch from normal mode mistimed");
  a_wait_bound: assert property (
    busy_cnt <= ASP_WAIT_CYC + ASP_GAP_CYC)
    else $error("switch never completes");
  // ==========================================================
  // Routing
  a_normal_route: assert property (quiet &&
    mode_o == ASP_MODE_NORMAL |=>
    sync_port_serial_out_pin_o == $past(spi_drv.dat_o) &&
    audio_codec_serial_out_pin_o == $past(ac_drv.dat_o) &&
    audio_codec_reset_pin_o == $past(ac_rst_n))
    else $error("normal mode routing wrong");
  a_ssp_route: assert property (quiet &&
    mode_o == ASP_MODE_I2S_SSP |=>
    sync_port_serial_out_pin_o == $past(i2s_drv.dat_o) &&
    audio_codec_serial_out_pin_o == $past(ac_drv.dat_o))
    else $error("sync-serial I2S routing wrong");
  a_ac_route: assert property (quiet &&
    mode_o == ASP_MODE_I2S_AC |=>
    audio_codec_reset_pin_o == $past(i2s_mclk) &&
    audio_codec_serial_out_pin_o == $past(i2s_drv.dat_o) &&
    sync_port_serial_out_pin_o == $past(spi_drv.dat_o))
    else $error("codec I2S routing wrong");
endmodule // asp_pin_mux_props

bind asp_pin_mux asp_pin_mux_props i_props (
  .clk, .rst, .mode_wr, .mode_wdata, .mode_o, .mode_busy, .mode_err,
  .spi_drv, .ac_drv, .i2s_drv, .ac_rst_n, .i2s_mclk,
  .sync_port_serial_out_pin_o, .audio_codec_serial_out_pin_o,
  .audio_codec_reset_pin_o
);

// [dv/test_asp_pin_mux.sv]
// Testbench: mode switching and pin routing of the audio pin mux
`timescale 1ns/10ps
module test_asp_pin_mux;
  import asp_pkg::*;
  logic clk, rst, mode_wr, ac_rst_n, i2s_mclk, run, short_frm, chk;
  logic mode_busy, mode_err, i2s_short, sck, ws, sd;
  logic [1:0] mode_wdata, i2s_ext_en, i2s_ext_dout, i2s_ext_din;
  logic [3:0] gpio_o, gpio_oe_n, gpio_i, gpio_pin_i;
  logic [3:0] gpio_pin_o, gpio_pin_oe_n, gp_d1, gp_d2;
  logic sb_o, sb_oe, sf_o, sf_oe, so_o, so_oe, ar_o, ab_o, ab_oe;
  logic af_o, af_oe, ao_o, ao_oe, sb_w, sf_w, ab_w, af_w;
  logic [8:0] now_v, exp_r;
  asp_mode_e mode_o, m;
  asp_drv_s spi_drv, ac_drv, i2s_drv;
  asp_rcv_s spi_rcv, ac_rcv, i2s_rcv;
  int error_cnt, n_tests, cyc, shorts;
  // ==========================================================
  // Wire levels and instances
  assign sb_w = sb_oe ? sck : sb_o;
  assign sf_w = sf_oe ? ws : sf_o;
  assign ab_w = ab_oe ? sck : ab_o;
  assign af_w = af_oe ? ws : af_o;
  assign now_v = {so_o, so_oe, ao_o, ao_oe, ar_o, gpio_pin_o[3],
    gpio_pin_o[1], gpio_pin_oe_n[2], gpio_pin_oe_n[0]};
  asp_link_peer i_peer (.run, .short_frm, .sck, .ws, .sd);
  asp_pin_mux i_dut (
    .clk, .rst, .mode_wr, .mode_wdata, .mode_o, .mode_busy, .mode_err,
    .i2s_short, .spi_drv, .spi_rcv, .ac_drv, .ac_rst_n, .ac_rcv, .i2s_drv,
    .i2s_mclk, .i2s_rcv, .i2s_ext_en, .i2s_ext_dout, .i2s_ext_din,
    .gpio_o, .gpio_oe_n, .gpio_i, .gpio_pin_i, .gpio_pin_o, .gpio_pin_oe_n,
    .sync_port_bit_clock_pin_i(sb_w), .sync_port_bit_clock_pin_o(sb_o),
    .sync_port_bit_clock_pin_oe_n(sb_oe), .sync_port_frame_pin_i(sf_w),
    .sync_port_frame_pin_o(sf_o), .sync_port_frame_pin_oe_n(sf_oe),
    .sync_port_serial_in_pin_i(sd), .sync_port_serial_out_pin_o(so_o),
    .sync_port_serial_out_pin_oe_n(so_oe), .audio_codec_reset_pin_o(ar_o),
    .audio_codec_bit_clock_pin_i(ab_w), .audio_codec_bit_clock_pin_o(ab_o),
    .audio_codec_bit_clock_pin_oe_n(ab_oe), .audio_codec_frame_pin_i(af_w),
    .audio_codec_frame_pin_o(af_o), .audio_codec_frame_pin_oe_n(af_oe),
    .audio_codec_serial_in_pin_i(sd), .audio_codec_serial_out_pin_o(ao_o),
    .audio_codec_serial_out_pin_oe_n(ao_oe));
  // ==========================================================
  // Expectation and checks
  function automatic logic [8:0] exp_pins(asp_mode_e md);
    logic s, a, e0, e1;
    s = md == ASP_MODE_I2S_SSP;
    a = md == ASP_MODE_I2S_AC;
    e0 = (s | a) & i2s_ext_en[0];
    e1 = (s | a) & i2s_ext_en[1];
    return {s ? i2s_drv.dat_o : spi_drv.dat_o,
      s ? i2s_drv.dat_oe_n : spi_drv.dat_oe_n,
      a ? i2s_drv.dat_o : ac_drv.dat_o, a ? i2s_drv.dat_oe_n : ac_drv.dat_oe_n,
      a ? i2s_mclk : ac_rst_n, e1 ? i2s_ext_dout[1] : gpio_o[3],
      e0 ? i2s_ext_dout[0] : gpio_o[1], e1 | gpio_oe_n[2], e0 | gpio_oe_n[0]};
  endfunction
  task automatic check(input logic [8:0] got, input logic [8:0] want);
    n_tests++;
    if (got !== want)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [1:0] code);
    @(posedge clk);
    mode_wr <= 1'b1;
    mode_wdata <= code;
    @(posedge clk);
    mode_wr <= 1'b0;
  endtask
  task automatic sw(input logic [1:0] code, input logic hold);
    int k;
    chk = 1'b0;
    run = !hold;
    wr(code);
    @(negedge clk);
    check(9'(mode_busy), 9'h1);
    if (hold)
    begin
      wr(2'h0);
      @(negedge clk);
      check(9'(mode_err), 9'h1);
      run = 1'b1;
    end
    for (k = 1; k < 1100 && mode_busy !== 1'b0; k++)
      @(negedge clk);
    if (m == ASP_MODE_NORMAL)
      check(9'(k - 1), 9'(ASP_GAP_CYC));
    check(9'(mode_o), 9'(code));
    m = asp_mode_e'(code);
    repeat (2) @(negedge clk);
    chk = 1'b1;
  endtask
  task automatic frm_chk(input asp_rcv_s off);
    @(ws);
    repeat (10) @(negedge clk);
    check(9'({i2s_rcv.frm_i, off}), 9'({ws, 3'h0}));
  endtask
  // ==========================================================
  // Clock, random drive, timeout
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    spi_drv <= asp_drv_s'(6'($urandom) | 6'h14);
    ac_drv <= asp_drv_s'(6'($urandom) | 6'h14);
    i2s_drv <= asp_drv_s'(6'($urandom) | 6'h14);
    {ac_rst_n, i2s_mclk, i2s_ext_en, i2s_ext_dout} <= 6'($urandom);
    {gpio_o, gpio_oe_n, gpio_pin_i} <= 12'($urandom);
  end
  always @(posedge clk)
    if (i2s_short === 1'b1)
      shorts++;
  always @(negedge clk)
  begin
    if (chk)
      check(now_v, exp_r);
    if (chk)
      check(9'(gpio_i), 9'(gp_d2));
    exp_r <= exp_pins(m);
    gp_d2 <= gp_d1;
    gp_d1 <= gpio_pin_i;
    cyc++;
    if (cyc > 20000)
    begin
      error_cnt++;
      wrap_up();
    end
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    void'($urandom(50));
    {rst, mode_wr, mode_wdata, run, short_frm, chk} = 7'h40;
    {ac_rst_n, i2s_mclk, i2s_ext_en, i2s_ext_dout, gpio_o} = 10'h0;
    {gpio_oe_n, gpio_pin_i} = 8'hf0;
    {spi_drv, ac_drv, i2s_drv} = {3{ASP_DRV_OFF}};
    m = ASP_MODE_NORMAL;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check({so_oe, ao_oe, sb_oe, sf_oe, ab_oe, af_oe, ar_o, mode_o},
      9'h1f8);
    @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(negedge clk);
    chk = 1'b1;
    repeat (200) @(negedge clk);
    wr(2'h3);
    @(negedge clk);
    check({6'h0, mode_err, mode_o}, 9'h4);
    wr(2'h0);
    @(negedge clk);
    check(9'(mode_err), 9'h0);
    sw(2'h1, 1'b0);
    repeat (400) @(negedge clk);
    frm_chk(spi_rcv);
    check(9'(shorts), 9'h0);
    short_frm = 1'b1;
    repeat (400) @(negedge clk);
    short_frm = 1'b0;
    repeat (400) @(negedge clk);
    check(9'(shorts > 0), 9'h1);
    sw(2'h2, 1'b1);
    repeat (300) @(negedge clk);
    frm_chk(ac_rcv);
    sw(2'h0, 1'b0);
    repeat (100) @(negedge clk);
    wrap_up();
  end
endmodule // test_asp_pin_mux

// [verilog/asp_pin_mux.sv]
// Module: pin sharing for SPI, AC'97 and three I2S ports
`timescale 1ns/10ps

// Functional notes
// RULE1: Normal mode: SPI on sync-serial pins, AC'97 on codec pins.
// RULE2: I2S-on-sync-serial mode: AC'97 port plus up to three I2S ports.
// RULE3: I2S-on-codec mode: SPI port plus up to three I2S ports.
// RULE4: I2S port 0 uses only the codec group or the sync-serial group.
// RULE5: I2S ports 1 and 2 data lines go to shared pins 4, 5, 6, 13.
// RULE6: I2S ports 1 and 2 reuse port 0 clocks; no clock pins of their own.
// RULE7: I2S never drives both pin groups at once.
// RULE8: I2S on sync-serial pins: clock, frame, in, out; no master clock.
// RULE9: I2S on codec pins: reset pin carries master clock, rest the link.
// RULE10: I2S ports carry two channels of 24-bit words.
// RULE11: Mode field resets to normal; illegal encodings are rejected.
module asp_pin_mux (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic mode_wr, // Mode field write strobe
  input wire logic [1:0] mode_wdata, // Mode field write value
  output asp_pkg::asp_mode_e mode_o, // Mode in force
  output logic mode_busy, // Mode switch in progress
  output logic mode_err, // Illegal or refused write
  output logic i2s_short, // I2S channel word too short
  input asp_pkg::asp_drv_s spi_drv, // SPI controller drive
  output asp_pkg::asp_rcv_s spi_rcv, // SPI controller receive
  input asp_pkg::asp_drv_s ac_drv, // AC'97 controller drive
  input wire logic ac_rst_n, // AC'97 controller codec reset
  output asp_pkg::asp_rcv_s ac_rcv, // AC'97 controller receive
  input asp_pkg::asp_drv_s i2s_drv, // I2S port 0 drive
  input wire logic i2s_mclk, // I2S master clock
  output asp_pkg::asp_rcv_s i2s_rcv, // I2S port 0 receive
  input wire logic [1:0] i2s_ext_en, // I2S ports 1,2 in use
  input wire logic [1:0] i2s_ext_dout, // I2S ports 1,2 data out
  output logic [1:0] i2s_ext_din, // I2S ports 1,2 data in
  input wire logic [3:0] gpio_o, // GPIO drive, pins 4,5,6,13
  input wire logic [3:0] gpio_oe_n, // GPIO enable, pins 4,5,6,13
  output logic [3:0] gpio_i, // GPIO pin levels
  input wire logic sync_port_bit_clock_pin_i, // Pin level
  output logic sync_port_bit_clock_pin_o, // Pin drive
  output logic sync_port_bit_clock_pin_oe_n, // Pin enable
  input wire logic sync_port_frame_pin_i, // Pin level
  output logic sync_port_frame_pin_o, // Pin drive
  output logic sync_port_frame_pin_oe_n, // Pin enable
  input wire logic sync_port_serial_in_pin_i, // Pin level
  output logic sync_port_serial_out_pin_o, // Pin drive
  output logic sync_port_serial_out_pin_oe_n, // Pin enable
  output logic audio_codec_reset_pin_o, // Codec reset / master clock
  input wire logic audio_codec_bit_clock_pin_i, // Pin level
  output logic audio_codec_bit_clock_pin_o, // Pin drive
  output logic audio_codec_bit_clock_pin_oe_n, // Pin enable
  input wire logic audio_codec_frame_pin_i, // Pin level
  output logic audio_codec_frame_pin_o, // Pin drive
  output logic audio_codec_frame_pin_oe_n, // Pin enable
  input wire logic audio_codec_serial_in_pin_i, // Pin level
  output logic audio_codec_serial_out_pin_o, // Pin drive
  output logic audio_codec_serial_out_pin_oe_n, // Pin enable
  input wire logic [3:0] gpio_pin_i, // Shared pin levels
  output logic [3:0] gpio_pin_o, // Shared pin drive
  output logic [3:0] gpio_pin_oe_n // Shared pin enable
);
  import asp_pkg::*;

  // ==========================================================
  // Pin input synchronisers
  logic [ASP_NSYNC-1:0] pin_raw;
  logic [ASP_NSYNC-1:0] sync1_r;
  logic [ASP_NSYNC-1:0] sync2_r;

  assign pin_raw = {gpio_pin_i,
                    audio_codec_serial_in_pin_i,
                    audio_codec_frame_pin_i,
                    audio_codec_bit_clock_pin_i,
                    sync_port_serial_in_pin_i,
                    sync_port_frame_pin_i,
                    sync_port_bit_clock_pin_i};

  genvar gi;
  generate
    for (gi = 0; gi < ASP_NSYNC; gi++)
    begin : g_sync
      always_ff @(posedge clk)
      begin
        sync1_r[gi] <= rst ? 1'b0 : pin_raw[gi];
        sync2_r[gi] <= rst ? 1'b0 : sync1_r[gi];
      end
    end
  endgenerate

  wire asp_rcv_s ssp_pins = {sync2_r[ASP_SI_SSP_CLK],
                             sync2_r[ASP_SI_SSP_FRM],
                             sync2_r[ASP_SI_SSP_DAT]};
  wire asp_rcv_s ac_pins = {sync2_r[ASP_SI_AC_CLK],
                            sync2_r[ASP_SI_AC_FRM],
                            sync2_r[ASP_SI_AC_DAT]};
  wire [3:0] gpio_sync = sync2_r[ASP_SI_GPIO +: 4];

  // ==========================================================
  // Mode field and switch sequencer
  asp_mode_e mode_r;
  asp_mode_e mode_nxt;
  asp_mode_e pend_r;
  asp_mode_e pend_nxt;
  asp_state_e st_r;
  asp_state_e st_nxt;
  logic [10:0] cnt_r;
  logic [10:0] cnt_nxt;
  logic mode_err_r;
  logic frame_edge;

  wire wr_legal = (mode_wdata == ASP_ENC_NORMAL) ||
                  (mode_wdata == ASP_ENC_I2S_SSP) ||
                  (mode_wdata == ASP_ENC_I2S_AC); // RULE11
  wire asp_mode_e wr_mode =
    (mode_wdata == ASP_ENC_I2S_SSP) ? ASP_MODE_I2S_SSP :
    (mode_wdata == ASP_ENC_I2S_AC) ? ASP_MODE_I2S_AC :
    ASP_MODE_NORMAL;
  wire running = (st_r == ASP_ST_RUN);
  wire i2s_mode = (mode_r != ASP_MODE_NORMAL);
  wire wr_take = mode_wr && wr_legal && running && (wr_mode != mode_r);

  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r + 11'h001;
    mode_nxt = mode_r;
    pend_nxt = pend_r;
    unique case (st_r)
      ASP_ST_RUN:
      begin
        cnt_nxt = 11'h000;
        if (wr_take)
        begin
          pend_nxt = wr_mode;
          // Let a running I2S link finish its channel word first
          st_nxt = i2s_mode ? ASP_ST_WAIT : ASP_ST_GAP;
        end
      end
      ASP_ST_WAIT:
      begin
        if (frame_edge || cnt_r == ASP_WAIT_CYC - 11'h001)
        begin
          st_nxt = ASP_ST_GAP;
          cnt_nxt = 11'h000;
        end
      end
      ASP_ST_GAP:
      begin
        if (cnt_r == ASP_GAP_CYC - 11'h001)
        begin
          st_nxt = ASP_ST_RUN;
          mode_nxt = pend_r;
          cnt_nxt = 11'h000;
        end
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mode_r <= ASP_MODE_NORMAL; // RULE11
      pend_r <= ASP_MODE_NORMAL;
      st_r <= ASP_ST_RUN;
      cnt_r <= 11'h000;
      mode_err_r <= 1'b0;
    end
    else
    begin
      mode_r <= mode_nxt;
      pend_r <= pend_nxt;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      mode_err_r <= mode_wr && (!wr_legal || !running); // RULE11
    end
  end

  assign mode_o = mode_r;
  assign mode_busy = !running;
  assign mode_err = mode_err_r;

  // ==========================================================
  // Group selection
  // Old routing holds through the wait so the frame edge can be seen
  wire linked = (st_r != ASP_ST_GAP);
  wire i2s_on_ssp = linked && mode_r == ASP_MODE_I2S_SSP; // RULE2
  wire i2s_on_ac = linked && mode_r == ASP_MODE_I2S_AC; // RULE3
  wire spi_on = linked && mode_r != ASP_MODE_I2S_SSP; // RULE1
  wire ac_on = linked && mode_r != ASP_MODE_I2S_AC; // RULE1
  wire i2s_on = i2s_on_ssp || i2s_on_ac;
  wire [1:0] ext_on = {2{i2s_on}} & i2s_ext_en; // RULE5

  // Each group takes at most one source, none during the gap; I2S never feeds both
  wire asp_drv_s ssp_nxt = i2s_on_ssp ? i2s_drv : // RULE8
                           spi_on ? spi_drv : ASP_DRV_OFF; // RULE7
  wire asp_drv_s ac_nxt = i2s_on_ac ? i2s_drv : // RULE9
                          ac_on ? ac_drv : ASP_DRV_OFF; // RULE4
  // Codec is held in reset while its pins are released
  wire rst_pin_nxt = i2s_on_ac ? i2s_mclk : // RULE9
                     ac_on ? ac_rst_n : 1'b0;

  // I2S ports 1 and 2 data only; their clocks are port 0's
  logic [3:0] gp_o_nxt;
  logic [3:0] gp_oe_n_nxt;
  assign gp_o_nxt[ASP_GP_I2S1_IN] = gpio_o[ASP_GP_I2S1_IN];
  assign gp_o_nxt[ASP_GP_I2S2_IN] = gpio_o[ASP_GP_I2S2_IN];
  assign gp_o_nxt[ASP_GP_I2S1_OUT] = ext_on[0] ? i2s_ext_dout[0] :
                                     gpio_o[ASP_GP_I2S1_OUT]; // RULE5
  assign gp_o_nxt[ASP_GP_I2S2_OUT] = ext_on[1] ? i2s_ext_dout[1] :
                                     gpio_o[ASP_GP_I2S2_OUT]; // RULE5
  assign gp_oe_n_nxt[ASP_GP_I2S1_IN] = ext_on[0] ||
                                       gpio_oe_n[ASP_GP_I2S1_IN];
  assign gp_oe_n_nxt[ASP_GP_I2S2_IN] = ext_on[1] ||
                                       gpio_oe_n[ASP_GP_I2S2_IN];
  assign gp_oe_n_nxt[ASP_GP_I2S1_OUT] = ext_on[0] ? 1'b0 :
                                        gpio_oe_n[ASP_GP_I2S1_OUT];
  assign gp_oe_n_nxt[ASP_GP_I2S2_OUT] = ext_on[1] ? 1'b0 :
                                        gpio_oe_n[ASP_GP_I2S2_OUT];

  wire asp_rcv_s i2s_pins = i2s_on_ssp ? ssp_pins : // RULE4
                            i2s_on_ac ? ac_pins : ASP_RCV_IDLE;

  // ==========================================================
  // Registered pin and controller outputs
  asp_drv_s ssp_r;
  asp_drv_s ac_r;
  logic rst_pin_r;
  logic [3:0] gp_o_r;
  logic [3:0] gp_oe_n_r;
  asp_rcv_s spi_rcv_r;
  asp_rcv_s ac_rcv_r;
  asp_rcv_s i2s_rcv_r;
  logic [1:0] ext_din_r;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ssp_r <= ASP_DRV_OFF;
      ac_r <= ASP_DRV_OFF;
      rst_pin_r <= 1'b0;
      gp_o_r <= 4'h0;
      gp_oe_n_r <= 4'hf;
      spi_rcv_r <= ASP_RCV_IDLE;
      ac_rcv_r <= ASP_RCV_IDLE;
      i2s_rcv_r <= ASP_RCV_IDLE;
      ext_din_r <= 2'h0;
    end
    else
    begin
      ssp_r <= ssp_nxt;
      ac_r <= ac_nxt;
      rst_pin_r <= rst_pin_nxt;
      gp_o_r <= gp_o_nxt;
      gp_oe_n_r <= gp_oe_n_nxt;
      spi_rcv_r <= spi_on ? ssp_pins : ASP_RCV_IDLE; // RULE1
      ac_rcv_r <= ac_on ? ac_pins : ASP_RCV_IDLE; // RULE1
      i2s_rcv_r <= i2s_pins;
      ext_din_r <= ext_on & {gpio_sync[ASP_GP_I2S2_IN],
                             gpio_sync[ASP_GP_I2S1_IN]}; // RULE6
    end
  end

  assign sync_port_bit_clock_pin_o = ssp_r.clk_o;
  assign sync_port_bit_clock_pin_oe_n = ssp_r.clk_oe_n;
  assign sync_port_frame_pin_o = ssp_r.frm_o;
  assign sync_port_frame_pin_oe_n = ssp_r.frm_oe_n;
  assign sync_port_serial_out_pin_o = ssp_r.dat_o;
  assign sync_port_serial_out_pin_oe_n = ssp_r.dat_oe_n;
  assign audio_codec_reset_pin_o = rst_pin_r;
  assign audio_codec_bit_clock_pin_o = ac_r.clk_o;
  assign audio_codec_bit_clock_pin_oe_n = ac_r.clk_oe_n;
  assign audio_codec_frame_pin_o = ac_r.frm_o;
  assign audio_codec_frame_pin_oe_n = ac_r.frm_oe_n;
  assign audio_codec_serial_out_pin_o = ac_r.dat_o;
  assign audio_codec_serial_out_pin_oe_n = ac_r.dat_oe_n;
  assign gpio_pin_o = gp_o_r;
  assign gpio_pin_oe_n = gp_oe_n_r;
  assign gpio_i = gpio_sync;
  assign spi_rcv = spi_rcv_r;
  assign ac_rcv = ac_rcv_r;
  assign i2s_rcv = i2s_rcv_r;
  assign i2s_ext_din = ext_din_r;

  // ==========================================================
  // I2S word length monitor on the sampled link clocks
  logic clk_prev_r;
  logic frm_prev_r;
  logic armed_r;
  logic [5:0] bits_r;
  logic short_r;

  wire sclk_rise = i2s_pins.clk_i && !clk_prev_r;
  wire frm_chg = sclk_rise && (i2s_pins.frm_i != frm_prev_r);
  assign frame_edge = frm_chg;
  wire word_short = armed_r && bits_r < ASP_I2S_WORD_BITS; // RULE10

  always_ff @(posedge clk)
  begin
    if (rst || !i2s_on)
    begin
      clk_prev_r <= 1'b0;
      frm_prev_r <= 1'b0;
      armed_r <= 1'b0;
      bits_r <= 6'h00;
      short_r <= 1'b0;
    end
    else
    begin
      clk_prev_r <= i2s_pins.clk_i;
      short_r <= frm_chg && word_short; // RULE10
      if (frm_chg)
      begin
        frm_prev_r <= i2s_pins.frm_i;
        armed_r <= 1'b1;
        bits_r <= 6'h01;
      end
      else if (sclk_rise && bits_r != 6'h3f)
        bits_r <= bits_r + 6'h01;
    end
  end

  assign i2s_short = short_r;

endmodule // asp_pin_mux

// [verilog/asp_pkg.sv]
// Package: constants and types for the audio/serial pin mux
package asp_pkg;

  // ==========================================================
  // Mode field encodings
  localparam logic [1:0] ASP_ENC_NORMAL = 2'h0;
  localparam logic [1:0] ASP_ENC_I2S_SSP = 2'h1;
  localparam logic [1:0] ASP_ENC_I2S_AC = 2'h2;
  localparam logic [1:0] ASP_ENC_RESET = ASP_ENC_NORMAL;

  typedef enum logic [1:0] {
    ASP_MODE_NORMAL,
    ASP_MODE_I2S_SSP,
    ASP_MODE_I2S_AC
  } asp_mode_e;

  typedef enum logic [1:0] {
    ASP_ST_RUN,
    ASP_ST_WAIT,
    ASP_ST_GAP
  } asp_state_e;

  // ==========================================================
  // Timing
  localparam int ASP_CLK_PERIOD_NS = 40;
  localparam int ASP_SWITCH_WAIT_NS = 40960;
  localparam int ASP_SWITCH_GAP_NS = 80;
  localparam logic [10:0] ASP_WAIT_CYC =
    11'(ASP_SWITCH_WAIT_NS / ASP_CLK_PERIOD_NS);
  localparam logic [10:0] ASP_GAP_CYC =
    11'(ASP_SWITCH_GAP_NS / ASP_CLK_PERIOD_NS);

  // ==========================================================
  // Audio format
  localparam logic [5:0] ASP_I2S_WORD_BITS = 6'h18;
  localparam int ASP_I2S_CHANNELS = 2;

  // ==========================================================
  // Positions in the synchronised pin vector
  localparam int ASP_NSYNC = 10;
  localparam int ASP_SI_SSP_CLK = 0;
  localparam int ASP_SI_SSP_FRM = 1;
  localparam int ASP_SI_SSP_DAT = 2;
  localparam int ASP_SI_AC_CLK = 3;
  localparam int ASP_SI_AC_FRM = 4;
  localparam int ASP_SI_AC_DAT = 5;
  localparam int ASP_SI_GPIO = 6;
  // Shared pin slots: 0=pin4 1=pin5 2=pin6 3=pin13
  localparam int ASP_GP_I2S1_IN = 0;
  localparam int ASP_GP_I2S1_OUT = 1;
  localparam int ASP_GP_I2S2_IN = 2;
  localparam int ASP_GP_I2S2_OUT = 3;

  // ==========================================================
  // Controller-side bundles
  typedef struct packed {
    logic clk_o;
    logic clk_oe_n;
    logic frm_o;
    logic frm_oe_n;
    logic dat_o;
    logic dat_oe_n;
  } asp_drv_s;

  typedef struct packed {
    logic clk_i;
    logic frm_i;
    logic dat_i;
  } asp_rcv_s;

  localparam asp_drv_s ASP_DRV_OFF = 6'h15;
  localparam asp_rcv_s ASP_RCV_IDLE = 3'h0;

endpackage
